// ===== bsfs_pkg.sv
// constants and types shared by the breaker startup and fault sequencer
package bsfs_pkg;
    // register map
    localparam logic [7:0] BSFS_CFG_ADDR = 8'hd0;
    localparam logic [7:0] BSFS_CFG_RESET = 8'h00;
    localparam int BSFS_CFG_THR_LSB = 0;
    localparam int BSFS_CFG_THR_W = 2;
    // address resistor decode
    localparam int BSFS_ADDR_CODE_W = 4;
    localparam logic [6:0] BSFS_ADDR_BASE = 7'h40;
    localparam int BSFS_ADDR_CODES = 12;
    // timing, in their own units, then in cycles at 50 MHz
    localparam int BSFS_CLK_KHZ = 50000;
    localparam int BSFS_GS_DEGLITCH_US = 10;
    localparam int BSFS_GS_MASK_MS = 100;
    localparam int BSFS_GS_DEGLITCH_CYC =
        BSFS_GS_DEGLITCH_US * BSFS_CLK_KHZ / 1000;
    localparam int BSFS_GS_MASK_CYC = BSFS_GS_MASK_MS * BSFS_CLK_KHZ;
    localparam int BSFS_CHECK_CYC = 2048;
    localparam int BSFS_DELAY_CYC = 4096;
    localparam int BSFS_CNT_W = 24;
    // sequencer states
    typedef enum logic [3:0] {
        BSFS_BIAS_WAIT = 4'b0000,
        BSFS_ADDR_READ = 4'b0001,
        BSFS_EN_WAIT = 4'b0010,
        BSFS_DELAY = 4'b0011,
        BSFS_SELF_CHECK = 4'b0100,
        BSFS_RAMP = 4'b0101,
        BSFS_NORMAL = 4'b0110,
        BSFS_FAULT = 4'b0111
    } bsfs_state_t;
endpackage

// ===== bsfs_deglitch.sv
// deglitch filter: output follows input only after it has held steady
`timescale 1ns/1ps
module bsfs_deglitch
    import bsfs_pkg::*;
#(
    parameter int CYCLES = 500
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // raw and filtered level
    input wire logic raw_in,
    output logic filt_out
);
    logic [BSFS_CNT_W-1:0] cnt_reg;

    // count cycles of disagreement, adopt the input when the count runs out
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            cnt_reg <= '0;
        end else if (cnt_reg == BSFS_CNT_W'(CYCLES - 1)) begin
            cnt_reg <= '0;
            filt_out <= raw_in;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // bsfs_deglitch

// ===== bsfs_sequencer.sv
// startup and latched-fault sequencer of the 12V breaker switch
`timescale 1ns/1ps
module bsfs_sequencer
    import bsfs_pkg::*;
#(
    parameter int GS_MASK_CYC = BSFS_GS_MASK_CYC,
    parameter int DELAY_CYC = BSFS_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // supply and input monitors
    input wire logic bias_supply_lockout,
    input wire logic input_supply_ok,
    input wire logic enable_undervoltage_input,
    input wire logic boost_supply_lockout,
    input wire logic boost_charged,
    input wire logic gate_drive_lockout,
    input wire logic current_limit_resistor_ok,
    // address resistor decoder
    input wire logic [BSFS_ADDR_CODE_W-1:0] addr_code,
    input wire logic addr_code_valid,
    // analog comparators
    input wire logic out_below_thr,
    input wire logic ss_below_thr,
    input wire logic ramp_done,
    input wire logic current_above_upper,
    input wire logic current_below_lower,
    // register port and restart command
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic restart_cmd,
    // controls and status
    output logic [6:0] slave_addr,
    output logic addr_pin_flag_out,
    output logic addr_pin_flag_oe,
    output logic out_discharge_en,
    output logic ss_discharge_en,
    output logic ss_charge_en,
    output logic pass_switch_on,
    output logic fault_n_out,
    output logic fault_n_oe,
    output logic power_good_output,
    output logic [3:0] state_out
);
    bsfs_state_t state_reg, state_next;
    logic [BSFS_CNT_W-1:0] tmr_reg, tmr_next;
    logic [BSFS_CNT_W-1:0] mask_reg;
    logic [7:0] cfg_reg;
    logic en_q_reg;
    logic supply_q_reg;
    logic addr_done_reg;
    logic addr_bad_reg;
    logic [1:0] en_rise_reg;
    logic hyst_reg;
    logic pg_fault_reg;
    logic gs_filt;

    // short gate-drive dips are filtered out
    bsfs_deglitch #(
        .CYCLES(BSFS_GS_DEGLITCH_CYC)
    ) u_gs_filter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .raw_in(gate_drive_lockout),
        .filt_out(gs_filt)
    );

    // event decode
    wire bias_ok = !bias_supply_lockout;
    wire en_rise = enable_undervoltage_input && !en_q_reg;
    wire en_fall = !enable_undervoltage_input && en_q_reg;
    wire supply_rise = input_supply_ok && !supply_q_reg;
    wire clear_evt = en_fall || supply_rise || restart_cmd;
    wire in_fault = (state_reg == BSFS_FAULT);
    wire tmr_done = (tmr_reg == '0);
    wire starting = (state_reg == BSFS_DELAY) ||
        (state_reg == BSFS_SELF_CHECK) || (state_reg == BSFS_RAMP);
    wire addr_range_ok = addr_code_valid &&
        (addr_code < BSFS_ADDR_CODE_W'(BSFS_ADDR_CODES));
    // lockouts only count once the device is enabled
    wire boost_trip = enable_undervoltage_input && boost_supply_lockout &&
        (starting || state_reg == BSFS_NORMAL);
    wire gs_trip = gs_filt && (mask_reg == '0) &&
        (state_reg == BSFS_RAMP || state_reg == BSFS_NORMAL);
    wire limit_trip = !current_limit_resistor_ok &&
        (state_reg != BSFS_BIAS_WAIT);
    wire self_fail = (state_reg == BSFS_SELF_CHECK) && tmr_done &&
        !out_below_thr;
    wire ss_fail = (state_reg == BSFS_SELF_CHECK) && tmr_done &&
        !ss_below_thr;
    // a pending reread must not trip again on the stale code
    wire addr_fail = (state_reg == BSFS_ADDR_READ) && addr_code_valid &&
        !addr_range_ok && !addr_bad_reg;
    wire any_fault = boost_trip || gs_trip || limit_trip || self_fail ||
        ss_fail || addr_fail;
    wire cfg_hit = (reg_addr == BSFS_CFG_ADDR);

    // next-state sequencing, fixed order through startup
    always_comb begin
        state_next = state_reg;
        tmr_next = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
        case (state_reg)
            BSFS_BIAS_WAIT: begin
                if (bias_ok) begin
                    state_next = addr_done_reg ? BSFS_EN_WAIT :
                        BSFS_ADDR_READ;
                end
            end
            BSFS_ADDR_READ: begin
                // enable is ignored here, except to release the reread
                if (addr_code_valid && addr_range_ok && boost_charged &&
                    !addr_bad_reg) begin
                    state_next = BSFS_EN_WAIT;
                end
            end
            BSFS_EN_WAIT: begin
                if (enable_undervoltage_input && !boost_supply_lockout) begin
                    state_next = BSFS_DELAY;
                    tmr_next = BSFS_CNT_W'(DELAY_CYC);
                end
            end
            BSFS_DELAY: begin
                if (tmr_done) begin
                    state_next = BSFS_SELF_CHECK;
                    tmr_next = BSFS_CNT_W'(BSFS_CHECK_CYC);
                end
            end
            BSFS_SELF_CHECK: begin
                if (tmr_done && out_below_thr && ss_below_thr) begin
                    state_next = BSFS_RAMP;
                end
            end
            BSFS_RAMP: begin
                if (ramp_done) begin
                    state_next = BSFS_NORMAL;
                end
            end
            BSFS_NORMAL: begin
                state_next = BSFS_NORMAL;
            end
            BSFS_FAULT: begin
                if (clear_evt) begin
                    state_next = BSFS_BIAS_WAIT;
                end
            end
            default: begin
                state_next = BSFS_BIAS_WAIT;
            end
        endcase
        // disable drops back to waiting, faults override it, bias loss overrides both
        if (starting || state_reg == BSFS_NORMAL) begin
            if (!enable_undervoltage_input) begin
                state_next = BSFS_EN_WAIT;
            end
        end
        if (any_fault && !in_fault) begin
            state_next = BSFS_FAULT;
        end
        if (!bias_ok) begin
            // bias loss: shut down, address kept so restart is at enable wait
            state_next = BSFS_BIAS_WAIT;
        end
    end

    // state and timer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= BSFS_BIAS_WAIT;
            tmr_reg <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
        end
    end

    // gate-drive mask counter, reloaded on entry into the ramp
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= '0;
        end else if (state_reg == BSFS_SELF_CHECK &&
            state_next == BSFS_RAMP) begin
            mask_reg <= BSFS_CNT_W'(GS_MASK_CYC);
        end else if (mask_reg != '0) begin
            mask_reg <= mask_reg - 1'b1;
        end
    end

    // edge history of enable and input supply
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_q_reg <= 1'b0;
            // supply idles high, so no false toggle right after reset
            supply_q_reg <= 1'b1;
        end else begin
            en_q_reg <= enable_undervoltage_input;
            supply_q_reg <= input_supply_ok;
        end
    end

    // address capture; a bad read waits for the second enable rise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slave_addr <= BSFS_ADDR_BASE;
            addr_done_reg <= 1'b0;
            addr_bad_reg <= 1'b0;
            en_rise_reg <= 2'b00;
        end else if (addr_fail) begin
            addr_bad_reg <= 1'b1;
            en_rise_reg <= 2'b00;
        end else if (state_reg == BSFS_ADDR_READ && addr_code_valid &&
            !addr_bad_reg) begin
            slave_addr <= BSFS_ADDR_BASE + 7'(addr_code);
            addr_done_reg <= 1'b1;
        end else if (addr_bad_reg && en_rise) begin
            en_rise_reg <= en_rise_reg + 2'b01;
            if (en_rise_reg == 2'b01) begin
                addr_bad_reg <= 1'b0;
                addr_done_reg <= 1'b0;
            end
        end
    end

    // hysteresis flag on the address pin once decoding is done
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hyst_reg <= 1'b0;
            addr_pin_flag_out <= 1'b0;
            addr_pin_flag_oe <= 1'b0;
        end else begin
            if (current_above_upper) begin
                hyst_reg <= 1'b1;
            end else if (current_below_lower) begin
                hyst_reg <= 1'b0;
            end
            addr_pin_flag_out <= hyst_reg;
            addr_pin_flag_oe <= addr_done_reg && state_reg != BSFS_ADDR_READ;
        end
    end

    // configuration register, threshold select in the low two bits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= BSFS_CFG_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && cfg_hit) begin
                cfg_reg <= reg_wdata;
            end
            reg_rdata <= cfg_hit ? cfg_reg : {4'h0, state_reg};
        end
    end

    // power-good fault latch; self-check failure also forces it low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pg_fault_reg <= 1'b0;
        end else if (self_fail) begin
            pg_fault_reg <= 1'b1;
        end else if (in_fault && clear_evt) begin
            pg_fault_reg <= 1'b0;
        end
    end

    // registered outputs, switch held off in every non-running state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_discharge_en <= 1'b0;
            ss_discharge_en <= 1'b0;
            ss_charge_en <= 1'b0;
            pass_switch_on <= 1'b0;
            fault_n_out <= 1'b0;
            fault_n_oe <= 1'b0;
            power_good_output <= 1'b0;
            state_out <= 4'h0;
        end else begin
            // the output is pulled down in bias wait, enable wait, self-check and fault, not in address read or delay
            out_discharge_en <= (state_next == BSFS_SELF_CHECK) ||
                (state_next == BSFS_EN_WAIT) || (state_next == BSFS_FAULT) ||
                (state_next == BSFS_BIAS_WAIT);
            ss_discharge_en <= (state_next == BSFS_SELF_CHECK);
            ss_charge_en <= (state_next == BSFS_RAMP) ||
                (state_next == BSFS_NORMAL);
            pass_switch_on <= (state_next == BSFS_RAMP) ||
                (state_next == BSFS_NORMAL);
            fault_n_out <= 1'b0;
            fault_n_oe <= (state_next == BSFS_FAULT);
            power_good_output <= (state_next == BSFS_NORMAL) &&
                !pg_fault_reg && !self_fail;
            state_out <= state_next;
        end
    end
endmodule // bsfs_sequencer

// ===== bsfs_checker_sva.sv
// assertion checker for the breaker startup and fault sequencer
`timescale 1ns/1ps
module bsfs_checker_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // watched inputs
    input wire logic bias_supply_lockout,
    input wire logic current_limit_resistor_ok,
    input wire logic current_above_upper,
    // watched outputs
    input wire logic addr_pin_flag_oe,
    input wire logic addr_pin_flag_out,
    input wire logic out_discharge_en,
    input wire logic ss_discharge_en,
    input wire logic pass_switch_on,
    input wire logic fault_n_out,
    input wire logic fault_n_oe,
    input wire logic power_good_output,
    input wire logic [3:0] state_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [11:0] chk_cnt_reg;
    // length of the current stay in self-check
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chk_cnt_reg <= 12'h000;
        end else begin
            chk_cnt_reg <= (state_out == 4'h4) ?
                chk_cnt_reg + 12'h001 : 12'h000;
        end
    end
    // self-check leaving to ramp or to fault
    sequence s_check_pass;
        state_out == 4'h4 ##1 state_out == 4'h5;
    endsequence
    sequence s_check_fail;
        state_out == 4'h4 ##1 state_out == 4'h7;
    endsequence
    a_fault_latch_off: assert property (
        state_out == 4'h7 |-> fault_n_oe && !fault_n_out && !pass_switch_on)
        else $error("fault state without fault line or with switch on");
    a_pg_normal_only: assert property (
        power_good_output |-> state_out == 4'h6)
        else $error("power good outside normal");
    a_check_fail_pg: assert property (
        s_check_fail |-> fault_n_oe && !power_good_output)
        else $error("failed check did not latch fault");
    a_check_period: assert property (
        s_check_pass |-> chk_cnt_reg inside {[2040:2056]})
        else $error("self-check period wrong");
    a_delay_after_wait: assert property (
        state_out == 4'h3 && $past(state_out) != 4'h3 |->
        $past(state_out) == 4'h2)
        else $error("delay entered not from enable wait");
    a_check_discharge: assert property (
        state_out == 4'h4 |-> out_discharge_en && ss_discharge_en)
        else $error("discharge off during self-check");
    a_bias_loss_stop: assert property (
        bias_supply_lockout && state_out inside {[3:6]} |=>
        state_out == 4'h0 && !pass_switch_on)
        else $error("bias loss did not shut down");
    a_limit_trip: assert property (
        !current_limit_resistor_ok && state_out inside {[1:6]} |=>
        state_out == 4'h7)
        else $error("bad current-limit resistor not latched");
    // the flag passes through two flops, so it shows two edges later
    a_hyst_set: assert property (
        addr_pin_flag_oe && current_above_upper |-> ##2 addr_pin_flag_out)
        else $error("hysteresis flag not set");
endmodule // bsfs_checker_sva

bind bsfs_sequencer bsfs_checker_sva bsfs_checker_sva_inst (
    .clk_sys, .resetn, .bias_supply_lockout, .current_limit_resistor_ok,
    .current_above_upper, .addr_pin_flag_oe, .addr_pin_flag_out,
    .out_discharge_en, .ss_discharge_en, .pass_switch_on, .fault_n_out,
    .fault_n_oe, .power_good_output, .state_out
);

// ===== bsfs_plant.sv
// plant model: output rail and soft-start capacitor seen by the sequencer
`timescale 1ns/1ps
module bsfs_plant (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // sequencer controls
    input wire logic out_discharge_en,
    input wire logic ss_discharge_en,
    input wire logic ss_charge_en,
    input wire logic pass_switch_on,
    // faults commanded by the bench
    input wire logic shorted,
    input wire logic ss_stuck,
    // comparator levels
    output logic out_below_thr,
    output logic ss_below_thr,
    output logic ramp_done
);
    logic [4:0] v_out_reg, v_ss_reg;
    // a shorted switch holds the rail up, a stuck cap never drains
    wire out_dn = out_discharge_en && !shorted && v_out_reg != 5'h00;
    wire out_up = pass_switch_on && v_out_reg != 5'h1f;
    wire ss_dn = ss_discharge_en && !ss_stuck && v_ss_reg != 5'h00;
    wire ss_up = ss_charge_en && v_ss_reg != 5'h1f;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            v_out_reg <= 5'h1f;
            v_ss_reg <= 5'h1f;
        end else begin
            v_out_reg <= v_out_reg - {4'h0, out_dn} + {4'h0, out_up};
            v_ss_reg <= v_ss_reg - {4'h0, ss_dn} + {4'h0, ss_up};
        end
    end
    assign out_below_thr = v_out_reg < 5'h08;
    assign ss_below_thr = v_ss_reg < 5'h08;
    assign ramp_done = pass_switch_on && v_out_reg == 5'h1f;
endmodule // bsfs_plant

// ===== breaker_startup_fault_sequencer_bench.sv
// self-checking bench for the breaker startup and fault sequencer
`timescale 1ns/1ps
module breaker_startup_fault_sequencer_bench
    import bsfs_pkg::*;
;
    logic clk_sys = 1'b0, resetn = 1'b0, bias = 1'b1, sup = 1'b1, en = 1'b0;
    logic bst = 1'b0, bst_ok = 1'b0, gate = 1'b0, cl_ok = 1'b1, av = 1'b0;
    logic up_i = 1'b0, lo_i = 1'b1, wr = 1'b0, rst_cmd = 1'b0;
    logic shorted = 1'b0, ss_stuck = 1'b0;
    logic [3:0] code = 4'hc;
    logic [7:0] ra = 8'h00, wd = 8'h00, rdata;
    logic [6:0] slave_addr;
    logic [3:0] st;
    logic fl_out, fl_oe, od_en, sd_en, sc_en, pass_on, f_out, f_oe, pg;
    logic ob, sb, rdone;
    int err_count = 0, comparisons = 0;

    bsfs_sequencer #(.GS_MASK_CYC(50), .DELAY_CYC(8)) bsfs_sequencer_inst (
        .clk_sys, .resetn, .bias_supply_lockout(bias), .input_supply_ok(sup),
        .enable_undervoltage_input(en), .boost_supply_lockout(bst),
        .boost_charged(bst_ok), .gate_drive_lockout(gate),
        .current_limit_resistor_ok(cl_ok), .addr_code(code),
        .addr_code_valid(av), .out_below_thr(ob), .ss_below_thr(sb),
        .ramp_done(rdone), .current_above_upper(up_i),
        .current_below_lower(lo_i), .reg_wr(wr), .reg_addr(ra),
        .reg_wdata(wd), .reg_rdata(rdata), .restart_cmd(rst_cmd),
        .slave_addr, .addr_pin_flag_out(fl_out), .addr_pin_flag_oe(fl_oe),
        .out_discharge_en(od_en), .ss_discharge_en(sd_en),
        .ss_charge_en(sc_en), .pass_switch_on(pass_on), .fault_n_out(f_out),
        .fault_n_oe(f_oe), .power_good_output(pg), .state_out(st));
    bsfs_plant bsfs_plant_inst (
        .clk_sys, .resetn, .out_discharge_en(od_en), .ss_discharge_en(sd_en),
        .ss_charge_en(sc_en), .pass_switch_on(pass_on), .shorted, .ss_stuck,
        .out_below_thr(ob), .ss_below_thr(sb), .ramp_done(rdone));

    // inputs move 1 ns after the rising edge, never on it
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bounded wait so a stuck sequencer ends as a mismatch
    task automatic wait_st(input logic [3:0] s);
        for (int i = 0; i < 3000 && st !== s; i++) cyc(1);
        check("state", {4'h0, st}, {4'h0, s});
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        ra = a;
        wd = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        // let one edge pass so a following write starts cleanly
        cyc(1);
    endtask
    // read data is registered one cycle after the address
    task automatic rd_reg(input logic [7:0] a, exp);
        ra = a;
        cyc(1);
        check("reg_rdata", rdata, exp);
    endtask
    task automatic restart();
        rst_cmd = 1'b1;
        cyc(1);
        rst_cmd = 1'b0;
    endtask
    task automatic up();
        wait_st(BSFS_SELF_CHECK);
        wait_st(BSFS_RAMP);
        check("pass_on", {7'h0, pass_on}, 8'h01);
        check("sc_en", {7'h0, sc_en}, 8'h01);
        wait_st(BSFS_NORMAL);
        check("pg", {7'h0, pg}, 8'h01);
    endtask
    task automatic t_reset();
        cyc(20);
        check("state", {4'h0, st}, 8'h00);
        check("addr", 8'(slave_addr), 8'(BSFS_ADDR_BASE));
        rd_reg(BSFS_CFG_ADDR, BSFS_CFG_RESET);
    endtask
    // out-of-range address, clear, reread on second enable rise
    task automatic t_addr();
        av = 1'b1;
        bias = 1'b0;
        wait_st(BSFS_FAULT);
        en = 1'b1;
        cyc(4);
        code = 4'h3;
        en = 1'b0;
        cyc(4);
        check("f_oe", {7'h0, f_oe}, 8'h00);
        // no reread yet: only the second enable rise releases it
        check("addr", 8'(slave_addr), 8'(BSFS_ADDR_BASE));
        en = 1'b1;
        cyc(10);
        check("state", {4'h0, st}, 8'h01);
        bst_ok = 1'b1;
        wait_st(BSFS_DELAY);
        check("addr", 8'(slave_addr), 8'(BSFS_ADDR_BASE + 7'h03));
        check("fl_oe", {7'h0, fl_oe}, 8'h01);
        up();
    endtask
    task automatic t_run();
        lo_i = 1'b0;
        up_i = 1'b1;
        cyc(3);
        check("fl_out", {7'h0, fl_out}, 8'h01);
        up_i = 1'b0;
        lo_i = 1'b1;
        cyc(3);
        check("fl_out", {7'h0, fl_out}, 8'h00);
        wr_reg(BSFS_CFG_ADDR, 8'h02);
        wr_reg(8'hd1, 8'h03);
        rd_reg(BSFS_CFG_ADDR, 8'h02);
        rd_reg(8'hd1, {4'h0, BSFS_NORMAL});
        gate = 1'b1;
        cyc(100);
        gate = 1'b0;
        cyc(600);
        check("state", {4'h0, st}, {4'h0, BSFS_NORMAL});
        gate = 1'b1;
        wait_st(BSFS_FAULT);
        gate = 1'b0;
        restart();
        up();
    endtask
    task automatic t_bias();
        bias = 1'b1;
        cyc(3);
        check("state", {4'h0, st}, 8'h00);
        bias = 1'b0;
        wait_st(BSFS_DELAY);
        up();
    endtask
    task automatic t_check_fail();
        en = 1'b0;
        cyc(3);
        check("od_en", {7'h0, od_en}, 8'h01);
        shorted = 1'b1;
        en = 1'b1;
        wait_st(BSFS_FAULT);
        check("pg", {7'h0, pg}, 8'h00);
        shorted = 1'b0;
        cyc(10);
        check("state", {4'h0, st}, {4'h0, BSFS_FAULT});
        en = 1'b0;
        cyc(3);
        check("f_oe", {7'h0, f_oe}, 8'h00);
        en = 1'b1;
        up();
    endtask
    task automatic t_faults();
        ss_stuck = 1'b1;
        en = 1'b0;
        cyc(3);
        en = 1'b1;
        wait_st(BSFS_FAULT);
        ss_stuck = 1'b0;
        restart();
        up();
        cl_ok = 1'b0;
        wait_st(BSFS_FAULT);
        cl_ok = 1'b1;
        sup = 1'b0;
        cyc(2);
        sup = 1'b1;
        up();
        bst = 1'b1;
        wait_st(BSFS_FAULT);
        check("f_oe", {7'h0, f_oe}, 8'h01);
    endtask
    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // about 18k cycles expected; over five times that is a hang
    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
    initial begin
        cyc(12);
        resetn = 1'b1;
        t_reset();
        t_addr();
        t_run();
        t_bias();
        t_check_fail();
        t_faults();
        stop_test();
    end
endmodule // breaker_startup_fault_sequencer_bench
